// ===== core/smcs_top.sv
// Function
// R1: serial clock times loading and forwarding
// R2: select high shifts data1 each rising edge
// R3: host sends enable then three select bits
// R4: enable zero all off, else binary port
// R5: host lowers select before next edge
// R6: select falling edge switches all off first
// R7: chosen port on after delay until next fall
// R8: latched enable low keeps ports off
// R9: select high forward driver on, return off
// R10: data2 shows bit after fourth edge
// R11: select low data2 passes to data1 directly
// R12: chain host sets exactly one enable
// R13: chained device with enable low stays off
// R14: host keeps serial clock under maximum
// R15: enable first, lands in final stage
// R16: hold shift register, apply at select fall
//
// Our own choices: the Wishbone register port and the placing of the registers.
`default_nettype none
module smcs_top
  import smcs_pkg::*;
#(
  parameter int TON_CYC = SMCS_TON_CYC,
  parameter int TURN_OFF_DELAY_CYC = SMCS_TURN_OFF_DELAY_CYC
)(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial link, synchronous samples
  input wire logic sck_i,
  input wire logic sel_n_i,
  input wire logic data1_i,
  output logic data1_o,
  output logic data1_oe_n_o,
  input wire logic data2_i,
  output logic data2_o,
  output logic data2_oe_n_o,
  // analog switch controls
  output logic [SMCS_NUM_CH-1:0] analog_ports_o,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  typedef enum {ST_OFF, ST_WAIT, ST_ON} smcs_state_type;
  smcs_state_type state_reg, state_next;
  logic sck_q_reg;
  logic sel_q_reg;
  logic [3:0] shift_reg;
  logic [3:0] latch_reg;
  logic [15:0] tmr_reg;
  logic [SMCS_NUM_CH-1:0] ports_reg;
  logic skid_rdy;
  logic skid_vld;
  logic skid_bit;
  logic d1_reg, d1_oe_n_reg, d2_reg, d2_oe_n_reg;
  logic [1:0] ctrl_reg;
  logic [31:0] rdat_reg;
  logic ack_reg;
  logic [31:0] fall_cnt_reg;
  // serial events on the system clock
  wire sck_rise = sck_i && !sck_q_reg; // R1
  wire sel_fall = !sel_n_i && sel_q_reg;
  wire sel_high = sel_n_i;
  wire shift_en = sel_high && sck_rise; // R2
  // enable enters first and drifts to the final stage
  wire [3:0] shift_next = {shift_reg[2:0], data1_i}; // R15
  wire [2:0] chan_num = latch_reg[SMCS_SEL_MSB:SMCS_SEL_LSB];
  wire chan_en = latch_reg[SMCS_EN_POS];
  wire [SMCS_NUM_CH-1:0] chan_onehot =
    chan_en ? (8'h01 << chan_num) : SMCS_PORTS_OFF; // R4 R8 R13
  // software override forces all off; shortcut cuts the delay to one cycle
  wire sw_force_off = ctrl_reg[0];
  wire sw_no_delay = ctrl_reg[1];
  wire [15:0] ton_len = sw_no_delay ? 16'h0001 : 16'(TON_CYC);
  wire tmr_done = (tmr_reg == 16'h0000);
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_OFF:
        if (sel_fall) state_next = ST_WAIT;
      ST_WAIT:
        if (sel_fall) state_next = ST_WAIT;
        else if (tmr_done) state_next = ST_ON;
      ST_ON:
        if (sel_fall) state_next = ST_WAIT;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sck_q_reg <= 1'b0;
      sel_q_reg <= 1'b1;
      shift_reg <= SMCS_SHIFT_RST;
      latch_reg <= SMCS_SHIFT_RST;
      state_reg <= ST_OFF;
      tmr_reg <= 16'h0000;
      ports_reg <= SMCS_PORTS_OFF;
    end
    else
    begin
      sck_q_reg <= sck_i;
      sel_q_reg <= sel_n_i;
      if (shift_en)
        shift_reg <= shift_next; // R2 R16
      if (sel_fall)
        latch_reg <= shift_reg; // R16
      state_reg <= state_next;
      if (sel_fall)
        tmr_reg <= ton_len - 16'h0001;
      else if (!tmr_done)
        tmr_reg <= tmr_reg - 16'h0001;
      // break before make: all off on every select fall
      if (sel_fall || state_next != ST_ON || sw_force_off)
        ports_reg <= SMCS_PORTS_OFF; // R6
      else
        ports_reg <= chan_onehot; // R7
    end
  end
  assign analog_ports_o = ports_reg;
  // data pins: drivers registered, one clock of latency, two for data2 through the skid
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      d1_reg <= 1'b0;
      d1_oe_n_reg <= 1'b1;
      d2_reg <= 1'b0;
      d2_oe_n_reg <= 1'b1;
    end
    else
    begin
      d2_oe_n_reg <= !sel_n_i; // R9 R11
      d1_oe_n_reg <= sel_n_i; // R9 R11
      if (skid_vld)
        d2_reg <= skid_bit; // R10
      d1_reg <= data2_i; // R11
    end
  end
  // the bit entering the final stage is staged, so a stall loses nothing;
  // after the fourth edge the first bit of the word reaches data2
  smcs_skid #(
    .WIDTH(1)
  ) i_fwd_skid (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(shift_en),
    .in_ready_o(skid_rdy),
    .in_data_i(shift_reg[SMCS_SHIFT_LEN-2]), // R10
    .out_valid_o(skid_vld),
    .out_ready_i(1'b1),
    .out_data_o(skid_bit)
  );
  assign data2_o = d2_reg;
  assign data2_oe_n_o = d2_oe_n_reg;
  assign data1_o = d1_reg;
  assign data1_oe_n_o = d1_oe_n_reg;
  // wishbone: one wait state, status reflects state
  wire wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  wire hit_ctrl = (wb_adr_i == SMCS_ADDR_CTRL);
  wire hit_stat = (wb_adr_i == SMCS_ADDR_STAT);
  wire [31:0] stat_word = {fall_cnt_reg[15:0], ports_reg,
    3'h0, (state_reg == ST_ON), latch_reg};
  wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_reg} :
    hit_stat ? stat_word : 32'h0;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
      ctrl_reg <= SMCS_CTRL_RST;
      fall_cnt_reg <= 32'h0;
    end
    else
    begin
      ack_reg <= wb_req;
      if (wb_req)
        rdat_reg <= rd_mux;
      if (wb_req && wb_we_i && hit_ctrl && wb_sel_i[0])
        ctrl_reg <= wb_dat_i[1:0];
      if (sel_fall)
        fall_cnt_reg <= fall_cnt_reg + 32'h1;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  a_ports_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
    $countones(ports_reg) <= 1) // R6
    else $error("two ports on");
  a_fall_off: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_fall |=> ports_reg == SMCS_PORTS_OFF) // R6
    else $error("ports not off after select fall");
  a_en_low_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !latch_reg[SMCS_EN_POS] |=> ports_reg == SMCS_PORTS_OFF) // R8
    else $error("ports on with enable low");
  a_hold_low: assert property (@(posedge clk_i) disable iff (rst_i)
    !sel_n_i && !$past(sel_n_i) |-> $stable(shift_reg)) // R16
    else $error("shift changed while select low");
  a_shift_in: assert property (@(posedge clk_i) disable iff (rst_i)
    shift_en |=> shift_reg[0] == $past(data1_i)) // R2
    else $error("shift missed data");
  a_fwd_drv: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_n_i |=> !data2_oe_n_o && data1_oe_n_o) // R9
    else $error("forward driver wrong");
  a_ret_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    !sel_n_i |=> data1_o == $past(data2_i) && data2_oe_n_o) // R11
    else $error("return path wrong");
  a_turn_on: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_fall ##1 (!sel_fall && !sw_force_off) [*2] |->
    ports_reg == SMCS_PORTS_OFF || chan_en) // R7
    else $error("turn on wrong");
  a_fwd_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    shift_en |=> ##1 data2_o == $past(shift_reg[2], 2)) // R10
    else $error("forward bit wrong");
  a_skid_room: assert property (@(posedge clk_i) disable iff (rst_i)
    skid_rdy) // R10
    else $error("forward buffer full");
  a_fall_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_fall |=> state_reg == ST_WAIT) // R7
    else $error("no wait after select fall");
  a_oe_excl: assert property (@(posedge clk_i) disable iff (rst_i)
    data1_oe_n_o || data2_oe_n_o) // R9
    else $error("both data drivers on");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  c_shift: cover property (@(posedge clk_i) shift_en);
  c_fall: cover property (@(posedge clk_i) sel_fall);
  c_on: cover property (@(posedge clk_i) ports_reg != SMCS_PORTS_OFF);
  c_en_low: cover property (@(posedge clk_i)
    sel_fall && !shift_reg[SMCS_EN_POS]);
endmodule : smcs_top
`default_nettype wire

// ===== include/smcs_pkg.sv
`default_nettype none
package smcs_pkg;
  localparam int SMCS_CLK_MHZ = 200;
  localparam int SMCS_SHIFT_LEN = 4;
  localparam int SMCS_NUM_CH = 8;
  // turn-on delay in ns, least time
  localparam int SMCS_TON_NS = 700;
  localparam int SMCS_TON_CYC = (SMCS_TON_NS * SMCS_CLK_MHZ + 999) / 1000;
  // turn-off delay in ns
  localparam int SMCS_TURN_OFF_DELAY_NS = 300;
  localparam int SMCS_TURN_OFF_DELAY_CYC = (SMCS_TURN_OFF_DELAY_NS * SMCS_CLK_MHZ + 999) / 1000;
  // max serial clock 5 MHz: 40 system clocks per serial period
  localparam int SMCS_SCK_MAX_MHZ = 5;
  localparam logic [3:0] SMCS_SHIFT_RST = 4'h0;
  localparam logic [7:0] SMCS_PORTS_OFF = 8'h00;
  localparam int SMCS_EN_POS = 3;
  localparam int SMCS_SEL_MSB = 2;
  localparam int SMCS_SEL_LSB = 0;
  // wishbone byte addresses
  localparam logic [3:0] SMCS_ADDR_CTRL = 4'h0;
  localparam logic [3:0] SMCS_ADDR_STAT = 4'h4;
  localparam logic [1:0] SMCS_CTRL_RST = 2'h0;
endpackage : smcs_pkg
`default_nettype wire

// ===== core/smcs_skid.sv
`default_nettype none
module smcs_skid
  import smcs_pkg::*;
#(
  parameter int WIDTH = 1
)(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] mem_reg [2];
  logic [1:0] cnt_reg;
  logic rd_reg;
  logic wr_reg;
  wire push = in_valid_i && (cnt_reg != 2'h2);
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (cnt_reg != 2'h2);
  assign out_valid_o = (cnt_reg != 2'h0);
  assign out_data_o = mem_reg[rd_reg];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= 2'h0;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
    end
    else
    begin
      if (push)
        wr_reg <= ~wr_reg;
      if (pop)
        rd_reg <= ~rd_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data_i;
  end
endmodule : smcs_skid
`default_nettype wire

// ===== test/smcs_host.sv
`default_nettype none
module smcs_host (
  // serial lines toward the device
  input wire logic clk_i,
  output logic sck_o,
  output logic sel_n_o,
  output logic dat_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {sck_o, sel_n_o, dat_o} = 3'h2;
  task automatic send(input logic [3:0] w);
    sel_n_o <= 1'b1;
    for (int i = 3; i >= 0; i--)
    begin
      dat_o <= w[i];
      sck_o <= 1'b0;
      // 40 system clocks a period keeps the link at its top rate
      repeat (20) @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (20) @(posedge clk_i);
    end
    // select drops together with the clock falling, so no fifth edge lands
    sel_n_o <= 1'b0;
    sck_o <= 1'b0;
    dat_o <= ~dat_o;
  endtask : send
endmodule : smcs_host
`default_nettype wire

// ===== test/test_serial_mux_channel_select.sv
`default_nettype none
module test_serial_mux_channel_select import smcs_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic data2_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic sck, sel_n, d1, d1_o, d1_oe_n, d2_o, d2_oe_n, ack;
  logic [7:0] ports;
  logic [31:0] rdat;
  logic [31:0] exp_q[$];
  int err_total = 0;
  int n_checks = 0;
  always #2.5 clk_i = ~clk_i;
  smcs_host i_host (.clk_i(clk_i), .sck_o(sck), .sel_n_o(sel_n), .dat_o(d1));
  smcs_top #(.TON_CYC(8)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck),
    .sel_n_i(sel_n), .data1_i(d1), .data1_o(d1_o), .data1_oe_n_o(d1_oe_n),
    .data2_i(data2_i), .data2_o(d2_o), .data2_oe_n_o(d2_oe_n),
    .analog_ports_o(ports), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(rdat), .wb_ack_o(ack));
  task automatic check(input string what, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wb_op(input logic we, input logic [3:0] a,
    input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
    @(posedge clk_i iff ack === 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : wb_op
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb_op(1'b0, a, 32'h0);
  endtask : rd
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // read data is judged when ack shows, against the oldest note
  always @(posedge clk_i)
    if (ack === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
      check("rd_data", rdat, exp_q.pop_front());
  initial
  begin
    #40us;
    err_total++;
    give_verdict;
  end
  initial
  begin
    logic [3:0] w;
    logic [7:0] pe;
    logic [15:0] falls;
    falls = 16'h0;
    void'($urandom(32'hDC54));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h8, 32'h0);
    rd(SMCS_ADDR_STAT, 32'h0);
    $display("test reset and unmapped done");
    for (int k = 0; k < 9; k++)
    begin
      // one word per frame: eight enabled words, one per port, then one with enable low
      w = (k < 8) ? {1'b1, 3'(k)} : {1'b0, 3'($urandom_range(7))};
      pe = w[3] ? 8'h01 << w[2:0] : 8'h00;
      fork
        i_host.send(w);
        begin
          repeat (30) @(posedge clk_i);
          check("oe_fwd", {d1_oe_n, d2_oe_n}, 2'h2);
        end
      join
      falls++;
      check("fwd_bit", d2_o, w[3]);
      repeat (4) @(posedge clk_i);
      check("ports_break", ports, 8'h00);
      repeat (12) @(posedge clk_i);
      check("ports_make", ports, pe);
      check("oe_back", {d1_oe_n, d2_oe_n}, 2'h1);
      data2_i <= 1'($urandom);
      repeat (3) @(posedge clk_i);
      check("pass_back", d1_o, data2_i);
      rd(SMCS_ADDR_STAT, {falls, pe, 3'h0, 1'b1, w});
      if (k == 7)
      begin
        wb_op(1'b1, SMCS_ADDR_CTRL, 32'h1);
        repeat (3) @(posedge clk_i);
        check("force_off", ports, 8'h00);
        wb_op(1'b1, SMCS_ADDR_CTRL, 32'h0);
      end
      $display("test word %h done", w);
    end
    give_verdict;
  end
endmodule : test_serial_mux_channel_select
`default_nettype wire
